// file: verilog/packet_rx_pkg.sv
package packet_rx_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Packet geometry
   localparam int PKT_BITS = 88;
   localparam int DST_ADDR_BITS = 24;
   localparam int DST_DATA_BITS = 64;
   localparam int PORT_MAX_WIDTH = 16;
   // Port-clock edges spent deserializing after the last beat
   localparam logic [1:0] DESER_LAT = 2'h3;

   // Beats per packet for each port width, rounded up
   localparam logic [6:0] BEATS_W1 = 7'h58;
   localparam logic [6:0] BEATS_W2 = 7'h2c;
   localparam logic [6:0] BEATS_W4 = 7'h16;
   localparam logic [6:0] BEATS_W8 = 7'h0b;
   localparam logic [6:0] BEATS_W16 = 7'h06;

   // Port width select codes
   localparam logic [2:0] WSEL_1 = 3'h0;
   localparam logic [2:0] WSEL_2 = 3'h1;
   localparam logic [2:0] WSEL_4 = 3'h2;
   localparam logic [2:0] WSEL_8 = 3'h3;
   localparam logic [2:0] WSEL_16 = 3'h4;
   localparam logic [2:0] WSEL_RESET = 3'h0;

   ////////////////////////////////////////////////////////////////////////
   // Register map
   localparam int AXI_ADDR_BITS = 8;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] COUNT_OFS = 8'h04;
   localparam int ONOFF_LSB = 0;
   localparam int WSEL_LSB = 4;
   localparam int BUSY_BIT = 8;
   localparam logic [3:0] ONOFF_OFF = 4'h5;
   localparam logic [3:0] ONOFF_RESET = 4'h5;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      DS_IDLE,
      DS_SHIFT,
      DS_SETTLE,
      DS_PUSH
   } deser_state_e;

endpackage

// file: verilog/two_entry_buffer.sv
`timescale 1ns/1ps
module two_entry_buffer #(
   parameter int WIDTH = 88
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] slot_reg [2];
   logic wr_ptr_reg;
   logic rd_ptr_reg;
   logic [1:0] count_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   // Honest full and empty
   assign in_ready = (count_reg != 2'h2);
   assign out_valid = (count_reg != 2'h0);
   assign out_data = slot_reg[rd_ptr_reg];

   // Slot storage, no reset needed
   always_ff @(posedge mclk) begin
      if (push) begin
         slot_reg[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge mclk) begin
      if (reset) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'h0;
      end else begin
         if (push) wr_ptr_reg <= ~wr_ptr_reg;
         if (pop) rd_ptr_reg <= ~rd_ptr_reg;
         if (push && !pop) count_reg <= count_reg + 2'h1;
         else if (pop && !push) count_reg <= count_reg - 2'h1;
      end
   end
endmodule

// file: verilog/packet_deserializer.sv
`timescale 1ns/1ps
module packet_deserializer (
   input wire logic mclk,
   input wire logic reset,
   input wire logic beat,
   input wire logic frame,
   input wire logic [packet_rx_pkg::PORT_MAX_WIDTH-1:0] port_data,
   input wire logic [2:0] wsel,
   input wire logic enable,
   output logic active,
   output logic pkt_valid,
   input wire logic pkt_ready,
   output logic [packet_rx_pkg::PKT_BITS-1:0] pkt_data
);
   localparam int PB = packet_rx_pkg::PKT_BITS;
   packet_rx_pkg::deser_state_e state_reg;
   logic [6:0] beat_cnt_reg;
   logic [1:0] settle_reg;
   logic [PB-1:0] shift_next;
   logic [6:0] beats_needed;

   // New shift value, oldest bits move up, newest land lowest
   always_comb begin
      case (wsel)
         packet_rx_pkg::WSEL_2: begin
            shift_next = {pkt_data[PB-3:0], port_data[1:0]};
            beats_needed = packet_rx_pkg::BEATS_W2;
         end
         packet_rx_pkg::WSEL_4: begin
            shift_next = {pkt_data[PB-5:0], port_data[3:0]};
            beats_needed = packet_rx_pkg::BEATS_W4;
         end
         packet_rx_pkg::WSEL_8: begin
            shift_next = {pkt_data[PB-9:0], port_data[7:0]};
            beats_needed = packet_rx_pkg::BEATS_W8;
         end
         packet_rx_pkg::WSEL_16: begin
            shift_next = {pkt_data[PB-17:0], port_data[15:0]};
            beats_needed = packet_rx_pkg::BEATS_W16;
         end
         default: begin
            shift_next = {pkt_data[PB-2:0], port_data[0]};
            beats_needed = packet_rx_pkg::BEATS_W1;
         end
      endcase
   end

   // Receive, settle, then hand to the buffer
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_reg <= packet_rx_pkg::DS_IDLE;
         beat_cnt_reg <= 7'h00;
         settle_reg <= 2'h0;
         active <= 1'b0;
         pkt_valid <= 1'b0;
         pkt_data <= '0;
      end else begin
         case (state_reg)
            packet_rx_pkg::DS_IDLE: begin
               if (beat && frame && enable) begin
                  pkt_data <= shift_next;
                  beat_cnt_reg <= 7'h01;
                  active <= 1'b1;
                  state_reg <= packet_rx_pkg::DS_SHIFT;
               end
            end
            packet_rx_pkg::DS_SHIFT: begin
               if (beat_cnt_reg == beats_needed) begin
                  settle_reg <= 2'h0;
                  state_reg <= packet_rx_pkg::DS_SETTLE;
               end else if (beat) begin
                  pkt_data <= shift_next;
                  beat_cnt_reg <= beat_cnt_reg + 7'h01;
               end
            end
            packet_rx_pkg::DS_SETTLE: begin
               if (beat) begin
                  if (settle_reg == packet_rx_pkg::DESER_LAT - 2'h1) begin
                     pkt_valid <= 1'b1;
                     state_reg <= packet_rx_pkg::DS_PUSH;
                  end else begin
                     settle_reg <= settle_reg + 2'h1;
                  end
               end
            end
            packet_rx_pkg::DS_PUSH: begin
               if (pkt_ready) begin
                  pkt_valid <= 1'b0;
                  active <= 1'b0;
                  state_reg <= packet_rx_pkg::DS_IDLE;
               end
            end
            default: begin
               state_reg <= packet_rx_pkg::DS_IDLE;
               active <= 1'b0;
               pkt_valid <= 1'b0;
            end
         endcase
      end
   end
endmodule

// file: verilog/packet_receive_busy_tracking.sv
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module packet_receive_busy_tracking (
   input wire logic mclk,
   input wire logic reset,
   // AXI4-Lite slave
   input wire logic [packet_rx_pkg::AXI_ADDR_BITS-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [packet_rx_pkg::AXI_ADDR_BITS-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Packet port from the debug tool
   input wire logic packet_port_clock,
   input wire logic port_frame,
   input wire logic [packet_rx_pkg::PORT_MAX_WIDTH-1:0] port_data,
   // Destination memory write port
   output logic dst_valid,
   input wire logic dst_ready,
   output logic [packet_rx_pkg::DST_ADDR_BITS-1:0] dst_addr,
   output logic [packet_rx_pkg::DST_DATA_BITS-1:0] dst_data,
   // Busy mirror of the global control register
   output logic busy
);
   localparam int PB = packet_rx_pkg::PKT_BITS;
   localparam int PW = packet_rx_pkg::PORT_MAX_WIDTH;
   localparam int DB = packet_rx_pkg::DST_DATA_BITS;

   ////////////////////////////////////////////////////////////////////////
   // Port synchronisers

   logic [PW+1:0] port_meta_reg;
   logic [PW+1:0] port_sync_reg;
   logic clk_seen_reg;
   logic sync_clk;
   logic sync_frame;
   logic [PW-1:0] sync_data;
   logic beat;

   // Two flops on every pin before use
   // Clock, frame and data pass the same flops, so a beat sees settled data
   always_ff @(posedge mclk) begin
      if (reset) begin
         port_meta_reg <= '0;
         port_sync_reg <= '0;
      end else begin
         port_meta_reg <= {packet_port_clock, port_frame, port_data};
         port_sync_reg <= port_meta_reg;
      end
   end

   // Unpack the synchronised pins
   assign sync_clk = port_sync_reg[PW+1];
   assign sync_frame = port_sync_reg[PW];
   assign sync_data = port_sync_reg[PW-1:0];
   assign beat = sync_clk && !clk_seen_reg;

   // Last port clock level, for rising edge detection
   always_ff @(posedge mclk) begin
      if (reset) begin
         clk_seen_reg <= 1'b0;
      end else begin
         clk_seen_reg <= sync_clk;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register state

   logic [3:0] on_off_reg;
   logic [2:0] wsel_reg;
   logic [31:0] pkt_count_reg;
   logic module_on;

   // Any code but the off pattern keeps reception enabled
   assign module_on = (on_off_reg != packet_rx_pkg::ONOFF_OFF);

   ////////////////////////////////////////////////////////////////////////
   // Deserializer and buffer

   logic deser_active;
   logic deser_valid;
   logic deser_ready;
   logic [PB-1:0] deser_data;
   logic buf_valid;
   logic buf_ready;
   logic [PB-1:0] buf_data;

   // New packets start only while on; a started one runs to the end
   // Switching off never cuts a packet: its data still reach memory
   packet_deserializer deser_u (
      .mclk(mclk),
      .reset(reset),
      .beat(beat),
      .frame(sync_frame),
      .port_data(sync_data),
      .wsel(wsel_reg),
      .enable(module_on),
      .active(deser_active),
      .pkt_valid(deser_valid),
      .pkt_ready(deser_ready),
      .pkt_data(deser_data)
   );

   // Holds deserialized packets until memory accepts them
   two_entry_buffer #(
      .WIDTH(PB)
   ) buf_u (
      .mclk(mclk),
      .reset(reset),
      .in_valid(deser_valid),
      .in_ready(deser_ready),
      .in_data(deser_data),
      .out_valid(buf_valid),
      .out_ready(buf_ready),
      .out_data(buf_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Destination memory write stage

   logic dst_load;
   logic dst_done;

   // Output register refills when empty or being taken
   assign buf_ready = !dst_valid || dst_ready;
   assign dst_load = buf_valid && buf_ready;
   assign dst_done = dst_valid && dst_ready;

   // Packet is address on top, data below
   always_ff @(posedge mclk) begin
      if (reset) begin
         dst_valid <= 1'b0;
         dst_addr <= '0;
         dst_data <= '0;
      end else if (dst_load) begin
         dst_valid <= 1'b1;
         dst_addr <= buf_data[PB-1:DB];
         dst_data <= buf_data[DB-1:0];
      end else if (dst_ready) begin
         dst_valid <= 1'b0;
      end
   end

   // Busy: receiving, buffered, or writing out
   // Registered, so it trails its terms by one mclk
   always_ff @(posedge mclk) begin
      if (reset) begin
         busy <= 1'b0;
      end else begin
         busy <= deser_active
            || deser_valid
            || buf_valid
            || dst_load
            || (dst_valid && !dst_ready);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write side

   logic aw_held_reg;
   logic w_held_reg;
   logic [packet_rx_pkg::AXI_ADDR_BITS-1:0] waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic wr_fire;
   logic wr_ctrl;

   // Write happens once address and data are both held
   assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign wr_ctrl = (waddr_reg == packet_rx_pkg::CTRL_OFS);

   // Address and data taken in either order
   // Ready stays low until the response is taken: one write at a time
   always_ff @(posedge mclk) begin
      if (reset) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         waddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
      end else if (wr_fire) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            s_axi_awready <= 1'b0;
            waddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Write response, error for unmapped or read-only words
   always_ff @(posedge mclk) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= packet_rx_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ctrl ? packet_rx_pkg::RESP_OKAY
                                : packet_rx_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control fields live in byte lane 0
   always_ff @(posedge mclk) begin
      if (reset) begin
         on_off_reg <= packet_rx_pkg::ONOFF_RESET;
         wsel_reg <= packet_rx_pkg::WSEL_RESET;
      end else if (wr_fire && wr_ctrl && wstrb_reg[0]) begin
         on_off_reg <= wdata_reg[packet_rx_pkg::ONOFF_LSB +: 4];
         wsel_reg <= wdata_reg[packet_rx_pkg::WSEL_LSB +: 3];
      end
   end

   // Count of packets handed to destination memory
   always_ff @(posedge mclk) begin
      if (reset) begin
         pkt_count_reg <= '0;
      end else if (dst_done) begin
         pkt_count_reg <= pkt_count_reg + 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read side

   logic [31:0] ctrl_view;
   logic [31:0] rd_word;
   logic rd_hit;

   // Read view of the global control register
   // Busy reads back as the flop, one mclk after its terms
   assign ctrl_view = {
      23'h000000,
      busy,
      1'b0,
      wsel_reg,
      on_off_reg
   };
   assign rd_hit = (s_axi_araddr == packet_rx_pkg::CTRL_OFS)
                || (s_axi_araddr == packet_rx_pkg::COUNT_OFS);
   assign rd_word = (s_axi_araddr == packet_rx_pkg::CTRL_OFS) ? ctrl_view
                  : (s_axi_araddr == packet_rx_pkg::COUNT_OFS)
                  ? pkt_count_reg : 32'h0000_0000;

   // One read at a time, data registered with its response
   always_ff @(posedge mclk) begin
      if (reset) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= packet_rx_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? packet_rx_pkg::RESP_OKAY
                               : packet_rx_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule

// file: test/packet_rx_chk.sv
`timescale 1ns/1ps
module packet_rx_chk (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic port_frame,
   input wire logic dst_valid,
   input wire logic dst_ready,
   input wire logic [23:0] dst_addr,
   input wire logic [63:0] dst_data,
   input wire logic busy
);
   // Common clock and reset
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   // Handshake terms
   wire wr_take;
   wire rd_take;
   wire dst_take;
   assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready;
   assign rd_take = s_axi_arvalid && s_axi_arready;
   assign dst_take = dst_valid && dst_ready;
   ////////////////////////////////////////////////////////////
   // Bus answers
   a_aw_block: assert property (s_axi_awvalid && s_axi_awready
      |=> !s_axi_awready) else $error("awready not dropped");
   a_b_after: assert property (wr_take |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b unstable");
   a_wr_refuse: assert property (wr_take
      && s_axi_awaddr != packet_rx_pkg::CTRL_OFS
      |-> ##[1:2] s_axi_bvalid && s_axi_bresp == packet_rx_pkg::RESP_SLVERR)
      else $error("bad write accepted");
   a_rd_answer: assert property (rd_take |=> s_axi_rvalid)
      else $error("read answer late");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("r unstable");
   a_rd_refuse: assert property (rd_take
      && s_axi_araddr != packet_rx_pkg::CTRL_OFS
      && s_axi_araddr != packet_rx_pkg::COUNT_OFS
      |=> s_axi_rresp == packet_rx_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("bad read accepted");
   // Busy and destination
   a_dst_hold: assert property (dst_valid && !dst_ready
      |=> dst_valid && $stable(dst_addr) && $stable(dst_data))
      else $error("dst unstable");
   a_dst_busy: assert property (dst_valid |-> busy)
      else $error("write without busy");
   a_busy_start: assert property ($rose(busy) |-> port_frame)
      else $error("busy rose outside frame");
   a_busy_fall: assert property ($fell(busy)
      |-> $past(dst_take) || $past(dst_take, 2)) else $error("busy fell");
endmodule

bind packet_receive_busy_tracking packet_rx_chk packet_rx_chk_inst (
   .mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_frame, .dst_valid,
   .dst_ready, .dst_addr, .dst_data, .busy
);

// file: test/packet_tool_model.sv
`timescale 1ns/1ps
module packet_tool_model (
   input wire logic send,
   input wire logic [2:0] wsel,
   input wire logic [87:0] pkt,
   output logic packet_port_clock,
   output logic port_frame,
   output logic [15:0] port_data,
   output logic tx_active,
   output int edges
);
   int w;
   int n;
   logic [95:0] p;
   // Idle port: clock stands still
   initial begin
      packet_port_clock = 1'b0;
      port_frame = 1'b0;
      port_data = 16'h0000;
      tx_active = 1'b0;
      edges = 0;
   end
   // Beats MSB first, then three trailing edges with data released
   always @(posedge send) begin
      tx_active = 1'b1;
      edges = 0;
      w = 1 << wsel;
      n = (88 + w - 1) / w;
      p = {8'h00, pkt};
      for (int i = 0; i < n + 3; i++) begin
         if (i < n) begin
            port_frame = 1'b1;
            port_data = 16'(p >> ((n - 1 - i) * w));
         end else if (i == n) begin
            port_frame = 1'b0;
            port_data = ~port_data; // Released lines do not keep the value
         end
         #200;
         packet_port_clock = 1'b1;
         edges = edges + 1;
         #200;
         packet_port_clock = 1'b0;
      end
      tx_active = 1'b0;
   end
endmodule

// file: test/packet_receive_busy_tracking_tb_top.sv
`timescale 1ns/1ps
module packet_receive_busy_tracking_tb_top;
   localparam logic [7:0] CTRL = packet_rx_pkg::CTRL_OFS;
   localparam logic [7:0] CNT = packet_rx_pkg::COUNT_OFS;
   localparam logic [1:0] OKAY = packet_rx_pkg::RESP_OKAY;
   localparam logic [1:0] SLVERR = packet_rx_pkg::RESP_SLVERR;
   localparam logic [3:0] OFF = packet_rx_pkg::ONOFF_OFF;
   logic mclk, reset, dst_ready, dst_valid, busy, send, tx_active;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, packet_port_clock, port_frame;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] port_data;
   logic [23:0] dst_addr;
   logic [63:0] dst_data;
   logic [2:0] m_wsel;
   logic [87:0] m_pkt;
   int edges, fail_count, n_compared, cycles, exp_count;
   int beats[5] = '{88, 44, 22, 11, 6};

   packet_receive_busy_tracking packet_receive_busy_tracking_inst (
      .mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .packet_port_clock, .port_frame,
      .port_data, .dst_valid, .dst_ready, .dst_addr, .dst_data, .busy
   );
   packet_tool_model packet_tool_model_inst (
      .send, .wsel(m_wsel), .pkt(m_pkt), .packet_port_clock, .port_frame,
      .port_data, .tx_active, .edges
   );
   // System clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // Hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 30000) begin
         fail_count++;
         complete_run();
      end
   end
   ////////////////////////////////////////////////////////////
   // Compare, report and bus tasks
   task automatic check_flag(input logic g, input logic e, input string m);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task automatic check_val(input logic [87:0] g, input logic [87:0] e,
         input string m);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %0t %s %h", $time, m, g);
      end
   endtask
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   function automatic logic [31:0] ctrl_word(input logic [2:0] w,
         input logic [3:0] o, input logic b);
      ctrl_word = 32'h0;
      ctrl_word[packet_rx_pkg::ONOFF_LSB +: 4] = o;
      ctrl_word[packet_rx_pkg::WSEL_LSB +: 3] = w;
      ctrl_word[packet_rx_pkg::BUSY_BIT] = b;
   endfunction
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] er);
      logic aw_open;
      logic w_open;
      @(posedge mclk);
      aw_open = 1'b1;
      w_open = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (aw_open || w_open) begin
         @(posedge mclk);
         if (aw_open && s_axi_awready) begin
            aw_open = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w_open && s_axi_wready) begin
            w_open = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge mclk);
      // Late bready leaves the response waiting one cycle
      s_axi_bready <= 1'b1;
      do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      check_val(88'(s_axi_bresp), 88'(er), "bresp");
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
         input logic [1:0] er);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge mclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge mclk);
      // Late rready leaves the answer waiting one cycle
      s_axi_rready <= 1'b1;
      do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      check_val(88'(s_axi_rdata), 88'(ed), "rdata");
      check_val(88'(s_axi_rresp), 88'(er), "rresp");
   endtask
   task automatic start_pkt(input logic [2:0] w, input logic [87:0] v);
      while (tx_active) @(posedge mclk);
      m_wsel <= w;
      m_pkt <= v;
      send <= 1'b1;
      @(posedge mclk);
      send <= 1'b0;
      while (!tx_active) @(posedge mclk);
   endtask
   // Stall the destination, then accept one packet
   task automatic take_pkt(input logic [87:0] v);
      while (dst_valid !== 1'b1) @(posedge mclk);
      repeat (3) @(posedge mclk);
      check_flag(busy, 1'b1, "busy while held");
      check_val({dst_addr, dst_data}, v, "dst word");
      dst_ready <= 1'b1;
      @(posedge mclk);
      dst_ready <= 1'b0;
      exp_count++;
   endtask
   ////////////////////////////////////////////////////////////
   // Scenarios
   task automatic test_regs;
      check_flag(busy, 1'b0, "busy at reset");
      axi_rd(CTRL, ctrl_word(3'h0, OFF, 1'b0), OKAY);
      axi_rd(CNT, 32'h0, OKAY);
      axi_rd(8'h08, 32'h0, SLVERR);
      axi_wr(CNT, 32'hffffffff, SLVERR);
      axi_wr(8'h0c, 32'h1, SLVERR);
      axi_rd(CNT, 32'h0, OKAY);
      axi_wr(CTRL, ctrl_word(3'h3, 4'ha, 1'b1), OKAY);
      axi_rd(CTRL, ctrl_word(3'h3, 4'ha, 1'b0), OKAY);
      s_axi_wstrb <= 4'he;
      axi_wr(CTRL, ctrl_word(3'h1, 4'h0, 1'b0), OKAY);
      s_axi_wstrb <= 4'hf;
      axi_rd(CTRL, ctrl_word(3'h3, 4'ha, 1'b0), OKAY);
      $display("regs done");
   endtask
   task automatic test_widths;
      logic [87:0] v;
      for (int k = 0; k < 5; k++) begin
         v = {24'ha1b2c3 ^ 24'(k), 64'h0123456789abcdef + 64'(k)};
         axi_wr(CTRL, ctrl_word(3'(k), 4'h0, 1'b0), OKAY);
         start_pkt(3'(k), v);
         repeat (12) @(posedge mclk);
         check_flag(busy, 1'b1, "busy at start");
         check_flag(dst_valid, 1'b0, "early write");
         while (dst_valid !== 1'b1) @(posedge mclk);
         check_val(88'(edges), 88'(beats[k] + 3), "edges");
         take_pkt(v);
         repeat (3) @(posedge mclk);
         check_flag(busy, 1'b0, "busy after drain");
      end
      $display("widths done");
   endtask
   task automatic test_off;
      logic [87:0] v;
      logic seen;
      v = 88'h5a0f1e3c4b5a6978879605;
      seen = 1'b0;
      axi_wr(CTRL, ctrl_word(3'h0, 4'h0, 1'b0), OKAY);
      start_pkt(3'h0, v);
      repeat (100) @(posedge mclk);
      axi_wr(CTRL, ctrl_word(3'h0, OFF, 1'b0), OKAY);
      check_flag(busy, 1'b1, "busy mid packet");
      take_pkt(v);
      repeat (95 * 8) @(posedge mclk);
      axi_rd(CTRL, ctrl_word(3'h0, OFF, 1'b0), OKAY);
      start_pkt(3'h0, ~v);
      while (tx_active) begin
         @(posedge mclk);
         seen = seen | busy | dst_valid;
      end
      repeat (20) @(posedge mclk);
      check_flag(seen | busy | dst_valid, 1'b0, "while off");
      $display("off done");
   endtask
   task automatic test_stall;
      logic [87:0] v[3];
      for (int k = 0; k < 3; k++) v[k] = {24'h00f000 + 24'(k), 64'(k) << 8};
      axi_wr(CTRL, ctrl_word(3'h4, 4'h0, 1'b0), OKAY);
      for (int k = 0; k < 3; k++) start_pkt(3'h4, v[k]);
      while (tx_active) @(posedge mclk);
      repeat (20) @(posedge mclk);
      check_flag(busy, 1'b1, "busy while buffered");
      for (int k = 0; k < 3; k++) take_pkt(v[k]);
      repeat (3) @(posedge mclk);
      check_flag(busy, 1'b0, "busy after drain");
      $display("stall done");
   endtask
   // Main sequence
   initial begin
      reset = 1'b1;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      dst_ready = 1'b0;
      send = 1'b0;
      m_wsel = 3'h0;
      m_pkt = 88'h0;
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      test_regs();
      test_widths();
      test_off();
      test_stall();
      axi_rd(CNT, 32'(exp_count), OKAY);
      complete_run();
   end
endmodule
